// file: tx_fault_pkg.sv
package tx_fault_pkg;

  // three-level strap encoding
  typedef enum logic [1:0] {
    LVL_LOW  = 2'b00,
    LVL_MID  = 2'b01,
    LVL_HIGH = 2'b10
  } level3_e;

  localparam int          CHAR_W          = 10;
  localparam logic [9:0]  BAD_CHAR_CODE   = 10'h0e7;
  localparam int          BIST_PASS_CHARS = 511;
  localparam int          WORD_SYNC_CHARS = 16;
  localparam int          LONG_PULSE      = 17;
  localparam int          SHORT_PULSE     = 1;
  localparam logic [1:0]  TX_MODE_LL      = 2'b00;
  localparam logic [9:0]  COUNT_RESET     = 10'h000;

  // static configuration straps
  typedef struct packed {
    level3_e    parity_check_control;
    level3_e    rx_clock_source_select;
    level3_e    tx_input_clock_select;
    logic       tx_reference_clock_rate_select;
    logic [1:0] tx_operating_select;
  } tx_cfg_s;

  // one captured character with its parity
  typedef struct packed {
    logic [9:0] data;
    logic       odd_parity;
  } tx_char_s;

endpackage

// file: tx_path_fault_indicator.sv
`timescale 1ns/1ps

// Functional notes
// - the fault flag changes only on the reference clock, never the host input clock.
// - with parity checking on, a parity error pulses the flag for one character period.
// - with parity checking on, a character with a parity error is replaced by the forced bad code.
// - the replacement happens in encoded and bypass modes alike.
// - in self-test the flag marks each pass, one pass lasting 511 characters.
// - with receive clock select low each pass adds a 16-character word sync sequence.
// - the pass pulse lasts one period for MID and seventeen for LOW or HIGH.
// - for LOW or HIGH with mode LL no word sync is added and the pulse is one period.
// - the phase-align buffer is on unless input clock select is low with rate select low.
// - with the buffer on, a buffer slip sets a held fault, cleared by a word sync or by the phase reset low.
// - odd parity from the host is checked by XOR over the captured character.
// - at half rate both reference edges are used, modelled here as one char per clk.
module tx_path_fault_indicator
  import tx_fault_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire tx_fault_pkg::tx_cfg_s  cfg,
  input  wire logic                   bist_enable,
  input  wire logic                   char_valid,
  input  wire tx_fault_pkg::tx_char_s char_in,
  input  wire logic                   buffer_slip,
  input  wire logic                   word_sync_done,
  input  wire logic                   tx_phase_align_reset_n,
  output logic [9:0]                  char_out,
  output logic                        char_out_valid,
  output logic                        buffer_enabled,
  output logic                        tx_fault_flag
);
  import tx_fault_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic       rst_meta;
  logic       rst_sync;
  logic       slip_meta;
  logic       slip_sync;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_meta  <= 1'b1;
      rst_sync  <= 1'b1;
      slip_meta <= 1'b0;
      slip_sync <= 1'b0;
    end else begin
      rst_meta  <= tx_phase_align_reset_n;
      rst_sync  <= rst_meta;
      slip_meta <= buffer_slip;
      slip_sync <= slip_meta;
    end
  end

  // ****************************************
  // parity check and substitution
  // ****************************************
  logic parity_on;
  logic parity_bad;
  logic parity_pulse;

  assign parity_on  = (cfg.parity_check_control != LVL_LOW);
  assign parity_bad = parity_on && char_valid &&
                      !(^{char_in.data, char_in.odd_parity});

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      char_out       <= COUNT_RESET;
      char_out_valid <= 1'b0;
      parity_pulse   <= 1'b0;
    end else begin
      char_out_valid <= char_valid;
      parity_pulse   <= parity_bad;
      if (parity_bad) begin
        char_out <= BAD_CHAR_CODE;
      end else if (char_valid) begin
        char_out <= char_in.data;
      end
    end
  end

  // ****************************************
  // self-test pass marker
  // ****************************************
  logic       sync_added;
  logic       long_pulse;
  logic [9:0] pass_len;
  logic [9:0] pass_cnt;
  logic [4:0] pulse_cnt;
  logic       pass_pulse;

  assign sync_added = (cfg.rx_clock_source_select == LVL_LOW) &&
                      (cfg.tx_operating_select != TX_MODE_LL);
  assign long_pulse = (cfg.rx_clock_source_select != LVL_MID) &&
                      (cfg.tx_operating_select != TX_MODE_LL);
  assign pass_len   = sync_added ? 10'(BIST_PASS_CHARS + WORD_SYNC_CHARS)
                                 : 10'(BIST_PASS_CHARS);
  assign pass_pulse = (pulse_cnt != 5'h00);

  always_ff @(posedge clk) begin
    if (sys_rst || !bist_enable) begin
      pass_cnt  <= COUNT_RESET;
      pulse_cnt <= 5'h00;
    end else begin
      if (pass_cnt == pass_len - 10'h001) begin
        pass_cnt  <= COUNT_RESET;
        pulse_cnt <= long_pulse ? 5'(LONG_PULSE) : 5'(SHORT_PULSE);
      end else begin
        pass_cnt <= pass_cnt + 10'h001;
        if (pulse_cnt != 5'h00) begin
          pulse_cnt <= pulse_cnt - 5'h01;
        end
      end
    end
  end

  // ****************************************
  // phase-align buffer fault
  // ****************************************
  logic buf_fault;

  assign buffer_enabled = (cfg.tx_input_clock_select != LVL_LOW) ||
                          cfg.tx_reference_clock_rate_select;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      buf_fault <= 1'b0;
    end else if (buffer_enabled && slip_sync) begin
      buf_fault <= 1'b1;
    end else if (word_sync_done || !rst_sync) begin
      buf_fault <= 1'b0;
    end
  end

  assign tx_fault_flag = parity_pulse || pass_pulse || buf_fault;

  // ****************************************
  // checks
  // ****************************************
  parity_one_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    parity_bad ##1 !parity_bad |-> tx_fault_flag ##1 (!tx_fault_flag || pass_pulse || buf_fault))
    else $error("parity pulse width wrong");
  bad_code_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
    parity_bad |=> char_out == BAD_CHAR_CODE)
    else $error("bad code not substituted");
  good_char_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
    char_valid && !parity_bad |=> char_out == $past(char_in.data))
    else $error("good char altered");
  long_pulse_a: assert property (@(posedge clk) disable iff (sys_rst || !bist_enable)
    $rose(pass_pulse) && long_pulse |-> pass_pulse [*8] ##0 (pulse_cnt == 5'd10))
    else $error("long pass pulse too short");
  short_pulse_a: assert property (@(posedge clk) disable iff (sys_rst || !bist_enable)
    $rose(pass_pulse) && !long_pulse |=> !pass_pulse)
    else $error("short pass pulse too long");
  pass_wrap_a: assert property (@(posedge clk) disable iff (sys_rst || !bist_enable)
    pass_cnt == 10'd510 && !sync_added |=> pass_cnt == 10'd0 && pass_pulse)
    else $error("pass length wrong");
  sync_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    sync_added |-> pass_len == 10'd527)
    else $error("word sync not added");
  buf_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg.tx_input_clock_select == LVL_LOW && !cfg.tx_reference_clock_rate_select |-> !buffer_enabled)
    else $error("buffer enable wrong");
  buf_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    buf_fault && !word_sync_done && rst_sync |=> buf_fault)
    else $error("buffer fault dropped");
  flag_or_a: assert property (@(posedge clk) disable iff (sys_rst)
    buf_fault |-> tx_fault_flag)
    else $error("flag misses buffer fault");

  parity_seen_c: cover property (@(posedge clk) parity_bad);
  pass_seen_c: cover property (@(posedge clk) $rose(pass_pulse) && long_pulse);
  slip_seen_c: cover property (@(posedge clk) $rose(buf_fault));
  recenter_c: cover property (@(posedge clk) $fell(buf_fault) && !rst_sync);
  short_pass_c: cover property (@(posedge clk) $rose(pass_pulse) && !long_pulse);

  // ****************************************
  // further checks
  // ****************************************
  valid_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    char_out_valid == $past(char_valid))
    else $error("output valid not delayed input valid");
  parity_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfg.parity_check_control == LVL_LOW && char_valid |=> char_out == $past(char_in.data))
    else $error("char replaced with parity check off");
  slip_sets_a: assert property (@(posedge clk) disable iff (sys_rst)
    buffer_enabled && slip_sync |=> buf_fault)
    else $error("buffer slip not flagged");
  slip_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
    !buffer_enabled && !buf_fault |=> !buf_fault)
    else $error("slip flagged with buffer off");
  recenter_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
    !rst_sync && !(buffer_enabled && slip_sync) |=> !buf_fault)
    else $error("phase reset did not clear fault");
  flag_parity_a: assert property (@(posedge clk) disable iff (sys_rst)
    parity_pulse |-> tx_fault_flag)
    else $error("flag misses parity pulse");
  flag_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
    pass_pulse |-> tx_fault_flag)
    else $error("flag misses pass pulse");
  base_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sync_added |-> pass_len == 10'd511)
    else $error("pass length not base length");
  bist_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !bist_enable |=> !pass_pulse)
    else $error("pass pulse with self-test off");

endmodule

// file: host_char_source.sv
`timescale 1ns/1ps
// ****
// host side character source
// ****
module host_char_source
  import tx_fault_pkg::*;
(
  input  wire logic              clk,
  output logic                   char_valid,
  output tx_fault_pkg::tx_char_s char_in
);
  initial begin
    char_valid = 1'b0;
    char_in    = '0;
  end
  // one char with odd parity, flipped when bad is set
  task automatic send(input logic [9:0] d, input logic bad);
    @(posedge clk);
    #1;
    char_valid = 1'b1;
    char_in    = '{data: d, odd_parity: ~^d ^ bad};
    @(posedge clk);
    #1;
    char_valid = 1'b0;
    char_in    = ~char_in;
  endtask
endmodule

// file: tb_tx_path_fault_indicator.sv
`timescale 1ns/1ps
module tb_tx_path_fault_indicator;
  import tx_fault_pkg::*;
  logic       clk, sys_rst, bist_enable, buffer_slip, word_sync_done, tx_phase_align_reset_n;
  logic       char_valid, char_out_valid, buffer_enabled, tx_fault_flag;
  logic [9:0] char_out;
  tx_cfg_s    cfg;
  tx_char_s   char_in;
  int         fails = 0;
  int         compares = 0;
  // ****
  // design and host
  // ****
  tx_path_fault_indicator i_tx_path_fault_indicator (.clk(clk), .sys_rst(sys_rst), .cfg(cfg),
    .bist_enable(bist_enable), .char_valid(char_valid), .char_in(char_in),
    .buffer_slip(buffer_slip), .word_sync_done(word_sync_done),
    .tx_phase_align_reset_n(tx_phase_align_reset_n), .char_out(char_out),
    .char_out_valid(char_out_valid), .buffer_enabled(buffer_enabled),
    .tx_fault_flag(tx_fault_flag));
  host_char_source i_host_char_source (.clk(clk), .char_valid(char_valid), .char_in(char_in));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // measures pulse width and rise to rise spacing
  task automatic bist_run(input level3_e rx, input logic [1:0] m, input int per, input int wid);
    int w;
    int p;
    w = 0;
    cfg.rx_clock_source_select = rx;
    cfg.tx_operating_select = m;
    bist_enable = 1'b1;
    for (int i = 0; i < 600 && tx_fault_flag !== 1'b1; i++) tick(1);
    while (tx_fault_flag === 1'b1 && w < 40) begin tick(1); w++; end
    p = w;
    while (tx_fault_flag !== 1'b1 && p < 600) begin tick(1); p++; end
    chk(w[9:0], wid[9:0]);
    chk(p[9:0], per[9:0]);
    bist_enable = 1'b0;
    tick(3);
  endtask
  // ****
  // tests
  // ****
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #40000;
    fails++;
    complete_run();
  end
  initial begin
    sys_rst = 1'b1; bist_enable = 1'b0; buffer_slip = 1'b0; word_sync_done = 1'b0;
    tx_phase_align_reset_n = 1'b1;
    cfg = '{LVL_MID, LVL_MID, LVL_MID, 1'b0, 2'b01};
    tick(5);
    sys_rst = 1'b0;
    chk(tx_fault_flag, 1'b0);
    for (int m = 0; m < 4; m++) begin
      cfg.tx_operating_select = m[1:0];
      i_host_char_source.send(10'h2a5, 1'b1);
      chk(char_out, BAD_CHAR_CODE);
      chk(char_out_valid, 1'b1);
      chk(tx_fault_flag, 1'b1);
      tick(1);
      chk(tx_fault_flag, 1'b0);
      i_host_char_source.send(10'h155 + m[9:0], 1'b0);
      chk(char_out, 10'h155 + m[9:0]);
      chk(tx_fault_flag, 1'b0);
    end
    cfg.parity_check_control = LVL_LOW;
    i_host_char_source.send(10'h0f0, 1'b1);
    chk(char_out, 10'h0f0);
    chk(tx_fault_flag, 1'b0);
    for (int k = 0; k < 6; k++) begin
      cfg.tx_input_clock_select = level3_e'(k / 2);
      cfg.tx_reference_clock_rate_select = k[0];
      tick(1);
      chk(buffer_enabled, (k >= 2) | k[0]);
    end
    cfg.tx_input_clock_select = LVL_LOW;
    cfg.tx_reference_clock_rate_select = 1'b0;
    buffer_slip = 1'b1; tick(1); buffer_slip = 1'b0; tick(5);
    chk(tx_fault_flag, 1'b0);
    cfg.tx_input_clock_select = LVL_MID;
    buffer_slip = 1'b1; tick(1); buffer_slip = 1'b0; tick(8);
    chk(tx_fault_flag, 1'b1);
    word_sync_done = 1'b1; tick(1); word_sync_done = 1'b0; tick(1);
    chk(tx_fault_flag, 1'b0);
    buffer_slip = 1'b1; tick(1); buffer_slip = 1'b0; tick(5);
    chk(tx_fault_flag, 1'b1);
    tx_phase_align_reset_n = 1'b0; tick(1); tx_phase_align_reset_n = 1'b1; tick(5);
    chk(tx_fault_flag, 1'b0);
    bist_run(LVL_MID, 2'b01, 511, 1);
    bist_run(LVL_LOW, 2'b01, 527, 17);
    bist_run(LVL_HIGH, 2'b01, 511, 17);
    bist_run(LVL_HIGH, TX_MODE_LL, 511, 1);
    bist_run(LVL_LOW, TX_MODE_LL, 511, 1);
    complete_run();
  end
endmodule
